// ===== shared/cmrc_defines.vh
`ifndef CMRC_DEFINES_VH
`define CMRC_DEFINES_VH
// Register byte offsets
`define CMRC_OFS_SYSCTL 8'h00
`define CMRC_OFS_STATUS 8'h04
`define CMRC_OFS_INTEN 8'h08
`define CMRC_OFS_INTPEND 8'h0C
`define CMRC_OFS_TIMING 8'h10
`define CMRC_OFS_WDTCTL 8'h14
// system_control_two fields
`define CMRC_BIT_XEN 7
`define CMRC_BIT_XTEN 6
`define CMRC_BIT_SYSCK 5
`define CMRC_SYSCTL_RESET 8'h80
// Status fields
`define CMRC_ST_CLKSEL 0
`define CMRC_ST_PEND 1
`define CMRC_ST_FAST_ONLY 2
`define CMRC_ST_DUAL_FAST 3
`define CMRC_ST_LOW_DUAL 4
`define CMRC_ST_LOW_ONLY 5
`define CMRC_ST_RST 6
`define CMRC_ST_FLASH 7
// Interrupt enable fields
`define CMRC_BIT_MASTER 8
`define CMRC_NUM_SRC 8
// Reset sequencing, counted in fc periods; fc is the pclk rate
`define CMRC_FC_MHZ 250
`define CMRC_MALF_FC_PERIODS 24
`define CMRC_FLASH_FC_PERIODS 1024
`define CMRC_MALF_CYCLES 11'h018
`define CMRC_FLASH_CYCLES 11'h400
`define CMRC_CNT_W 11
`define CMRC_RESET_VECTOR 16'hFFFE
`define CMRC_PRESC_W 16
`endif

// ===== logic/cmrc_reset_seq.v
`include "cmrc_defines.vh"
module cmrc_reset_seq (
  input wire pclk,
  input wire presetn,
  input wire ext_hold,
  input wire malf_req,
  output reg rst_active,
  output reg malf_active,
  output reg flash_active
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_MALF = 4'h2;
  localparam [3:0] ST_EXT = 4'h4;
  localparam [3:0] ST_FLASH = 4'h8;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [`CMRC_CNT_W-1:0] cnt;
  reg [`CMRC_CNT_W-1:0] next_cnt;
  always @*
  begin
    next_state = state;
    next_cnt = cnt + 11'h001;
    case (state)
      ST_IDLE:
      begin
        next_cnt = 11'h000;
        if (malf_req)
          next_state = ST_MALF;
      end
      ST_MALF:
      begin
        if (cnt == `CMRC_MALF_CYCLES - 11'h001)
        begin
          next_state = ST_FLASH;
          next_cnt = 11'h000;
        end
      end
      ST_EXT:
      begin
        next_cnt = 11'h000;
        if (!ext_hold)
          next_state = ST_FLASH;
      end
      ST_FLASH:
      begin
        if (cnt == `CMRC_FLASH_CYCLES - 11'h001)
        begin
          next_state = ST_IDLE;
          next_cnt = 11'h000;
        end
        else if (malf_req)
        begin
          next_state = ST_MALF;
          next_cnt = 11'h000;
        end
      end
      default:
      begin
        next_state = ST_MALF;
        next_cnt = 11'h000;
      end
    endcase
    if (ext_hold)
    begin
      next_state = ST_EXT;
      next_cnt = 11'h000;
    end
  end
  // Power-up enters the malfunction phase: that circuit is not cleared at power-on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_MALF;
      cnt <= 11'h000;
      rst_active <= 1'b1;
      malf_active <= 1'b1;
      flash_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      rst_active <= (next_state != ST_IDLE);
      malf_active <= (next_state == ST_MALF);
      flash_active <= (next_state == ST_FLASH);
    end
  end
endmodule // cmrc_reset_seq

// ===== logic/cmrc_top.v
// Added by the designer: the APB register port and the address map.
`include "cmrc_defines.vh"
// How it works
// - Writing 1 to the clock select bit moves the system clock onto the low-frequency source.
// - Writing 0 to the high-frequency enable bit stops that oscillator and completes low-clock-only mode.
// - The high-frequency oscillator may stay on while the low clock runs the system.
// - A low external reset ends slow mode and the part restarts in fast-clock-only mode.
// - After clock select is cleared the low clock stays in use until a low-clock edge aligns the switch.
// - External, address trap, watchdog and system clock resets are accepted; the last three are malfunction resets.
// - A malfunction reset holds internal reset for at most 24 fast clock periods.
// - An 11-stage counter adds a flash reset interval right after every malfunction and external reset.
// - The flash reset interval lasts 1024 fast clock periods.
// - The malfunction stage is not cleared at power-up, so power-on gives the full malfunction plus flash reset.
// - Reset clears the master interrupt enable, every source enable and every pending latch.
// - Reset clears the timing generator prescaler.
module cmrc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_reset_n,
  input wire lf_clk_pin,
  input wire addr_trap_req,
  input wire wdt_reset_req,
  input wire [7:0] int_req,
  output reg hf_osc_en,
  output reg lf_osc_en,
  output reg sys_clk_low,
  output reg internal_reset,
  output reg flash_reset,
  output reg [15:0] pc_vector,
  output reg pc_load,
  output reg wdt_enable,
  output reg master_int_enable,
  output reg [7:0] per_source_int_enable,
  output reg [7:0] int_pending_latch,
  output reg [15:0] timing_prescaler
);
  // Fault check for a clock-enable update that would leave the CPU without a clock
  function sysclk_fault;
    input [7:0] cur;
    input [7:0] nxt;
    begin
      sysclk_fault = (cur[`CMRC_BIT_XEN] & cur[`CMRC_BIT_XTEN] &
                      ~nxt[`CMRC_BIT_XEN] & ~nxt[`CMRC_BIT_XTEN]) |
                     (cur[`CMRC_BIT_XEN] & ~nxt[`CMRC_BIT_XEN] & ~cur[`CMRC_BIT_SYSCK]) |
                     (cur[`CMRC_BIT_XTEN] & ~nxt[`CMRC_BIT_XTEN] & cur[`CMRC_BIT_SYSCK]);
    end
  endfunction

  // Low byte of a 32-bit word, taken whole for an 8-bit register
  function [7:0] low_byte;
    input [31:0] w;
    begin
      low_byte = w[7:0];
    end
  endfunction

  reg ext_s1;
  reg ext_s2;
  reg ext_s3;
  reg ext_lvl;
  reg lf_s1;
  reg lf_s2;
  reg lf_s3;
  reg lf_lvl;
  reg lf_lvl_d;
  reg [7:0] system_control_two;
  reg switch_pend;
  reg sysclk_rst_req;
  reg [7:0] int_req_d;
  wire rst_active;
  wire malf_active;
  wire flash_active;
  wire apb_access;
  wire apb_wr;
  wire apb_rd_setup;
  wire lf_rise;
  wire malf_req;
  wire [7:0] wr_byte;
  wire [7:0] pend_set;
  wire [7:0] pend_clr;
  wire [7:0] status_word;
  wire mode_fast_only;
  wire mode_dual_fast;
  wire mode_low_dual;
  wire mode_low_only;

  assign apb_access = psel & penable & pready;
  assign apb_wr = apb_access & pwrite;
  assign apb_rd_setup = psel & penable & ~pready & ~pwrite;
  assign wr_byte = low_byte(pwdata);
  assign lf_rise = lf_lvl & ~lf_lvl_d;

  // External reset pin: three stages, level moves when the last two agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
      ext_lvl <= 1'b1;
    end
    else
    begin
      ext_s1 <= ext_reset_n;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3)
        ext_lvl <= ext_s3;
    end
  end

  // Low-frequency clock arrives as a pin; only its filtered level is used
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lf_s1 <= 1'b0;
      lf_s2 <= 1'b0;
      lf_s3 <= 1'b0;
      lf_lvl <= 1'b0;
      lf_lvl_d <= 1'b0;
    end
    else
    begin
      lf_s1 <= lf_clk_pin;
      lf_s2 <= lf_s1;
      lf_s3 <= lf_s2;
      if (lf_s2 == lf_s3)
        lf_lvl <= lf_s3;
      lf_lvl_d <= lf_lvl;
    end
  end

  // Malfunction sources; the clock fault is latched for one cycle
  assign malf_req = addr_trap_req | wdt_reset_req | sysclk_rst_req;

  cmrc_reset_seq i_cmrc_reset_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ext_hold(~ext_lvl),
    .malf_req(malf_req),
    .rst_active(rst_active),
    .malf_active(malf_active),
    .flash_active(flash_active)
  );

  // Clock mode control
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_control_two <= `CMRC_SYSCTL_RESET;
      sysclk_rst_req <= 1'b0;
    end
    else if (rst_active)
    begin
      system_control_two <= `CMRC_SYSCTL_RESET;
      sysclk_rst_req <= 1'b0;
    end
    else
    begin
      sysclk_rst_req <= 1'b0;
      if (apb_wr && paddr == `CMRC_OFS_SYSCTL)
      begin
        // Oscillators keep running on a fault; the reset restores the register anyway
        if (sysclk_fault(system_control_two, wr_byte))
          sysclk_rst_req <= 1'b1;
        else
          system_control_two <= wr_byte & 8'hE0;
      end
    end
  end

  // Effective clock source; the return to the fast clock waits for a low-clock edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_clk_low <= 1'b0;
      switch_pend <= 1'b0;
    end
    else if (rst_active)
    begin
      sys_clk_low <= 1'b0;
      switch_pend <= 1'b0;
    end
    else if (system_control_two[`CMRC_BIT_SYSCK])
    begin
      sys_clk_low <= 1'b1;
      switch_pend <= 1'b0;
    end
    else if (sys_clk_low)
    begin
      switch_pend <= ~lf_rise;
      if (lf_rise)
        sys_clk_low <= 1'b0;
    end
    else
      switch_pend <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hf_osc_en <= 1'b1;
      lf_osc_en <= 1'b0;
      internal_reset <= 1'b1;
      flash_reset <= 1'b0;
      pc_vector <= `CMRC_RESET_VECTOR;
      pc_load <= 1'b0;
    end
    else
    begin
      hf_osc_en <= system_control_two[`CMRC_BIT_XEN] | rst_active;
      lf_osc_en <= system_control_two[`CMRC_BIT_XTEN] & ~rst_active;
      internal_reset <= rst_active;
      flash_reset <= flash_active;
      pc_vector <= `CMRC_RESET_VECTOR;
      pc_load <= internal_reset & ~rst_active;
    end
  end

  // Interrupt state; a new request wins over a same-cycle clear
  assign pend_clr = (apb_wr && paddr == `CMRC_OFS_INTPEND) ? wr_byte : 8'h00;
  assign pend_set = int_req & ~int_req_d;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_int_enable <= 1'b0;
      per_source_int_enable <= 8'h00;
      int_pending_latch <= 8'h00;
      int_req_d <= 8'h00;
    end
    else if (rst_active)
    begin
      master_int_enable <= 1'b0;
      per_source_int_enable <= 8'h00;
      int_pending_latch <= 8'h00;
      int_req_d <= int_req;
    end
    else
    begin
      int_req_d <= int_req;
      int_pending_latch <= (int_pending_latch & ~pend_clr) | pend_set;
      if (apb_wr && paddr == `CMRC_OFS_INTEN)
      begin
        master_int_enable <= pwdata[`CMRC_BIT_MASTER];
        per_source_int_enable <= wr_byte;
      end
    end
  end

  // Timing generator prescaler and watchdog enable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timing_prescaler <= 16'h0000;
      wdt_enable <= 1'b1;
    end
    else if (rst_active)
    begin
      timing_prescaler <= 16'h0000;
      wdt_enable <= 1'b1;
    end
    else
    begin
      timing_prescaler <= timing_prescaler + 16'h0001;
      if (apb_wr && paddr == `CMRC_OFS_WDTCTL)
        wdt_enable <= pwdata[0];
    end
  end

  assign mode_fast_only = ~sys_clk_low & ~system_control_two[`CMRC_BIT_XTEN];
  assign mode_dual_fast = ~sys_clk_low & system_control_two[`CMRC_BIT_XTEN];
  assign mode_low_dual = sys_clk_low & system_control_two[`CMRC_BIT_XEN];
  assign mode_low_only = sys_clk_low & ~system_control_two[`CMRC_BIT_XEN];
  assign status_word = {flash_active, rst_active, mode_low_only, mode_low_dual,
                        mode_dual_fast, mode_fast_only, switch_pend, sys_clk_low};

  // APB slave: one wait state, ready and data both from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready)
      begin
        case (paddr)
          `CMRC_OFS_SYSCTL: prdata <= {24'h000000, system_control_two};
          `CMRC_OFS_STATUS: prdata <= {24'h000000, status_word};
          `CMRC_OFS_INTEN: prdata <= {23'h0, master_int_enable, per_source_int_enable};
          `CMRC_OFS_INTPEND: prdata <= {24'h000000, int_pending_latch};
          `CMRC_OFS_TIMING: prdata <= {16'h0000, timing_prescaler};
          `CMRC_OFS_WDTCTL: prdata <= {31'h0, wdt_enable};
          default: pslverr <= 1'b1;
        endcase
        if (!apb_rd_setup)
          prdata <= 32'h00000000;
      end
    end
  end
endmodule // cmrc_top

// ===== verification/cmrc_props.sv
module cmrc_props (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic ext_reset_n,
  input logic addr_trap_req,
  input logic hf_osc_en,
  input logic sys_clk_low,
  input logic internal_reset,
  input logic flash_reset,
  input logic pc_load,
  input logic [15:0] pc_vector,
  input logic master_int_enable,
  input logic [7:0] per_source_int_enable,
  input logic [7:0] int_pending_latch,
  input logic [15:0] timing_prescaler
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [10:0] fl_cnt;
  logic [10:0] ml_cnt;
  // One cycle of slack: the reset output is registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_cnt <= 11'h000;
      ml_cnt <= 11'h000;
    end
    else
    begin
      fl_cnt <= flash_reset ? fl_cnt + 11'h001 : 11'h000;
      // A held reset pin may last any length; only the malfunction part is bounded
      ml_cnt <= (internal_reset && !flash_reset && ext_reset_n) ? ml_cnt + 11'h001 : 11'h000;
    end
  end
  sequence in_reset;
    internal_reset && $past(internal_reset);
  endsequence
  sequence trap_seen;
    addr_trap_req && !internal_reset;
  endsequence
  sequence ext_low;
    !ext_reset_n [*6];
  endsequence
  sequence sysck_wr;
    psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[7:5] == 3'h7 && !internal_reset;
  endsequence
  apb_answer_a: assert property (psel && $rose(penable) |=> pready) else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready stuck");
  presc_clear_a: assert property (in_reset |-> timing_prescaler == 16'h0000) else $error("prescaler");
  int_clear_a: assert property (in_reset |-> !master_int_enable && per_source_int_enable == 8'h00
    && int_pending_latch == 8'h00) else $error("int state");
  fast_restart_a: assert property (in_reset |-> hf_osc_en && !sys_clk_low) else $error("clock in reset");
  ext_hold_a: assert property (ext_low |-> ##[0:4] internal_reset) else $error("no ext reset");
  flash_len_a: assert property ($fell(flash_reset) |-> fl_cnt == 11'h400) else $error("flash len");
  malf_len_a: assert property (ml_cnt <= 11'h019) else $error("malf too long");
  flash_inside_a: assert property (flash_reset |-> internal_reset) else $error("flash alone");
  flash_last_a: assert property ($fell(internal_reset) |-> $past(flash_reset)) else $error("no flash");
  trap_reset_a: assert property (trap_seen |-> ##[1:8] internal_reset) else $error("trap ignored");
  low_select_a: assert property (sysck_wr |-> ##[1:2] sys_clk_low) else $error("no low clock");
  vector_load_a: assert property ($fell(internal_reset) |-> ##[0:2] (pc_load && pc_vector == 16'hFFFE))
    else $error("no vector load");
endmodule // cmrc_props

bind cmrc_top cmrc_props i_cmrc_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .ext_reset_n, .addr_trap_req, .hf_osc_en, .sys_clk_low, .internal_reset, .flash_reset, .pc_load, .pc_vector,
  .master_int_enable, .per_source_int_enable, .int_pending_latch, .timing_prescaler);

// ===== verification/cmrc_test.sv
module cmrc_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, ext_reset_n, lf_clk_pin, addr_trap_req, wdt_reset_req;
  logic pready, pslverr, hf_osc_en, lf_osc_en, sys_clk_low, internal_reset, flash_reset, pc_load;
  logic wdt_enable, master_int_enable, er;
  logic [7:0] paddr, int_req, per_source_int_enable, int_pending_latch;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pc_vector, timing_prescaler;
  integer n_mismatch, n_checks, ml, fl, src, k;
  cmrc_top i_cmrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_reset_n, .lf_clk_pin, .addr_trap_req, .wdt_reset_req, .int_req, .hf_osc_en, .lf_osc_en,
    .sys_clk_low, .internal_reset, .flash_reset, .pc_vector, .pc_load, .wdt_enable, .master_int_enable,
    .per_source_int_enable, .int_pending_latch, .timing_prescaler);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up;
    chk(32'h0, 32'h1);
    give_verdict();
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Counts malfunction and flash cycles of one reset
  task automatic measure;
    ml = 0;
    fl = 0;
    k = 0;
    while (internal_reset !== 1'b1 && k < 40)
    begin
      @(posedge pclk);
      k++;
    end
    if (internal_reset !== 1'b1)
      give_up();
    while (internal_reset === 1'b1 && k < 3000)
    begin
      @(posedge pclk);
      k++;
      fl += (flash_reset === 1'b1);
      ml += (internal_reset === 1'b1 && flash_reset !== 1'b1);
    end
    if (k >= 3000)
      give_up();
  endtask
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    {psel, penable, pwrite, ext_reset_n, lf_clk_pin, addr_trap_req, wdt_reset_req, presetn} = 8'h10;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_req = 8'h00;
    tick(8);
    presetn <= 1'b1;
    measure();
    chk(fl, 32'h400);
    chk(ml <= 32'h19, 32'h1);
    rdc(8'h00, 32'h80);
    chk({hf_osc_en, sys_clk_low, wdt_enable, pc_vector}, 32'h5FFFE);
    for (src = 0; src < 3; src++)
    begin
      wr(8'h08, 32'h1FF);
      int_req <= 8'h08;
      rdc(8'h0C, 32'h08);
      int_req <= 8'h00;
      wr(8'h0C, 32'h08);
      rdc(8'h0C, 32'h00);
      wr(8'h00, 32'hC0);
      wr(8'h00, 32'hE0);
      tick(2);
      chk({hf_osc_en, lf_osc_en, sys_clk_low}, 32'h7);
      rdc(8'h04, 32'h11);
      if (src == 0)
        wr(8'h00, 32'hA0);
      else
      begin
        addr_trap_req <= (src == 1);
        wdt_reset_req <= (src == 2);
        tick(1);
        addr_trap_req <= 1'b0;
        wdt_reset_req <= 1'b0;
      end
      measure();
      chk(fl, 32'h400);
      chk(ml <= 32'h19, 32'h1);
      chk({master_int_enable, per_source_int_enable, int_pending_latch}, 32'h0);
      rdc(8'h08, 32'h0);
      rdc(8'h00, 32'h80);
    end
    wr(8'h00, 32'hC0);
    wr(8'h00, 32'hE0);
    wr(8'h00, 32'h60);
    tick(2);
    chk({hf_osc_en, sys_clk_low}, 32'h1);
    rdc(8'h04, 32'h21);
    wr(8'h00, 32'hE0);
    tick(2);
    chk(hf_osc_en, 32'h1);
    wr(8'h00, 32'hC0);
    tick(8);
    chk(sys_clk_low, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h2, 32'h2);
    lf_clk_pin <= 1'b1;
    k = 0;
    while (sys_clk_low !== 1'b0 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    chk(sys_clk_low, 32'h0);
    if (sys_clk_low !== 1'b0)
      give_up();
    lf_clk_pin <= 1'b0;
    wr(8'h00, 32'hE0);
    wr(8'h14, 32'h0);
    rdc(8'h14, 32'h0);
    ext_reset_n <= 1'b0;
    tick(10);
    ext_reset_n <= 1'b1;
    measure();
    chk(timing_prescaler < 16'h0010, 32'h1);
    chk(fl, 32'h400);
    chk(sys_clk_low, 32'h0);
    rdc(8'h00, 32'h80);
    rdc(8'h14, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    give_verdict();
  end
endmodule // cmrc_test
